/* spi_frame_sync_control.sv */
/*
  Framed serial port: register bank on Avalon-MM, bit engine, frame sync.
  Assumes pins arrive asynchronously and sck_in is slow against sys_clk.
*/
// Our own choice: the Avalon-MM interface to the registers.
// Behaviour
// - Framed enable turns select pin into sync
// - Direction bit: sync input or driven output
// - Polarity bit picks active-high or low pulse
// - Auto-select drives select pin while master busy
// - Width bit: one character or one bit
// - Pulse every 1 to 32 characters
// - Clock source, deep buffer locked while on
// - Clock edge bit ignored when framed
// - Audio mode forces idle polarity high
// - Clear, set, invert aliases at 4/8/C
// - Unimplemented bits read zero, ignore writes
// - Edge bit: pulse with first bit, or before it in master mode only
// - Enable bit runs or halts the port
`timescale 1ns/1ps
`include "spi_fs_params.svh"
module spi_frame_sync_control
  import spi_fs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        ss_in,
  output logic             ss_out,
  output logic             ss_oe,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             irq
);
  logic [31:0] ctrl_q, baud_q, ctrl2_q, tx_q, rx_q;
  logic [31:0] irq_stat_q, irq_mask_q, tx_sh_q, rx_sh_q;
  logic        ack_q, tx_full_q, rbf_q, rov_q;
  logic        sck_lvl_q, ss_out_q, ss_oe_q;
  logic [12:0] hp_q;
  logic [6:0]  hcnt_q;
  logic [5:0]  bitn_q, char_cnt_q;
  xfer_state_t st_q;

  edge_if #(.W(3)) pins ();
  assign pins.raw = {sdi, ss_in, sck_in};
  pin_edge_sync u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .e       (pins)
  );

  // Bus handshake: one wait cycle per access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  wire       wr_take = avs_write & ack_q & ce;
  wire       rd_take = avs_read & ack_q & ce;
  wire       on_reg  = ({avs_address[15:4], 4'h0} == `OFS_CTRL);
  wire       on_stat = ({avs_address[15:4], 4'h0} == `OFS_STAT);
  wire       on_baud = ({avs_address[15:4], 4'h0} == `OFS_BAUD);
  wire       on_c2   = ({avs_address[15:4], 4'h0} == `OFS_CTRL2);
  wire       on_ist  = ({avs_address[15:4], 4'h0} == `OFS_IRQ_STAT);
  wire       on_imsk = ({avs_address[15:4], 4'h0} == `OFS_IRQ_MASK);
  wire       on_data = (avs_address == `OFS_DATA);
  alias_op_t op;
  assign op = alias_op_t'(avs_address[3:2]);

  wire [31:0] be = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic logic [31:0] alias_apply(
    input logic [31:0] old,
    input logic [31:0] wd,
    input alias_op_t   o
  );
    case (o)
      OP_CLR:  alias_apply = old & ~wd;
      OP_SET:  alias_apply = old | wd;
      OP_INV:  alias_apply = old ^ wd;
      default: alias_apply = wd;
    endcase
  endfunction : alias_apply

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] m
  );
    merge = (old & ~m) | (alias_apply(old, avs_writedata, op) & m);
  endfunction : merge

  wire on      = ctrl_q[`B_ON];
  wire master  = ctrl_q[`B_MASTER];
  wire framed  = ctrl_q[`B_FRAMED];
  wire fs_dir  = ctrl_q[`B_FS_DIR];
  wire fs_pol  = ctrl_q[`B_FS_POL];
  wire fs_wide = ctrl_q[`B_FS_WIDE];
  wire [2:0] fcnt = ctrl_q[`B_FCNT_LO +: 3];
  wire edge_sel = ctrl_q[`B_EDGE_SEL];
  wire audio_protocol_enable   = ctrl2_q[`B_AUDIO];
  // idle polarity forced in audio mode
  wire ckp_eff = ctrl_q[`B_CKP] | audio_protocol_enable;
  // clock edge bit ignored when framed
  wire cke_eff = ctrl_q[`B_CKE] & ~framed;
  wire busy    = (st_q != ST_IDLE);

  wire [31:0] ctrl_wm = be & `CTRL_MASK & ~(on ? `CTRL_LOCK : 32'h0);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q     <= `CTRL_RESET;
      baud_q     <= 32'h0;
      ctrl2_q    <= 32'h0;
      irq_mask_q <= 32'h0;
    end else if (wr_take) begin
      if (on_reg)  ctrl_q     <= merge(ctrl_q, ctrl_wm);
      if (on_baud) baud_q     <= merge(baud_q, be & `BAUD_MASK);
      if (on_c2)   ctrl2_q    <= merge(ctrl2_q, be & `CTRL2_MASK);
      if (on_imsk) irq_mask_q <= merge(irq_mask_q, be & `IRQ_BITS);
    end
  end

  wire [31:0] stat_rd = ({31'h0, rbf_q} << `S_RBF) | ({31'h0, ~tx_full_q} << `S_TBE)
                      | ({31'h0, rov_q} << `S_ROV) | ({31'h0, busy} << `S_BUSY);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (ce & avs_read & ~ack_q) begin
      if (on_reg)       avs_readdata <= ctrl_q;
      else if (on_stat) avs_readdata <= stat_rd;
      else if (on_data) avs_readdata <= rx_q;
      else if (on_baud) avs_readdata <= baud_q;
      else if (on_c2)   avs_readdata <= ctrl2_q;
      else if (on_ist)  avs_readdata <= irq_stat_q;
      else if (on_imsk) avs_readdata <= irq_mask_q;
      else              avs_readdata <= 32'h0;
    end
  end

  // Character length and frame period
  wire [5:0] nbits = ctrl_q[`B_MODE32] ? 6'd32 : (ctrl_q[`B_MODE16] ? 6'd16 : 6'd8);
  logic [31:0] nmask;
  always_comb begin
    case (nbits)
      6'd8:    nmask = 32'h000000FF;
      6'd16:   nmask = 32'h0000FFFF;
      default: nmask = 32'hFFFFFFFF;
    endcase
  end
  // reserved codes act as every character
  wire [5:0] frame_len = (fcnt > 3'h5) ? 6'h1 : 6'(6'h1 << fcnt);

  // Event sources
  wire tick    = (hp_q == baud_q[12:0]);
  wire m_run   = master & (st_q == ST_XFER) & tick;
  wire m_lead  = m_run & (sck_lvl_q == ckp_eff);
  wire m_trail = m_run & (sck_lvl_q != ckp_eff);
  wire s_xfer  = ~master & (st_q == ST_XFER);
  wire s_lead  = s_xfer & (ckp_eff ? pins.fall[0] : pins.rise[0]);
  wire s_trail = s_xfer & (ckp_eff ? pins.rise[0] : pins.fall[0]);
  wire lead    = m_lead | s_lead;
  wire trail   = m_trail | s_trail;
  wire sample_ev = cke_eff ? lead : trail;
  wire shift_ev  = (cke_eff ? trail : lead) & (bitn_q != 6'h0);
  wire [31:0] rx_next = sample_ev ? {rx_sh_q[30:0], pins.lvl[2]} : rx_sh_q;
  wire m_done = m_trail & (hcnt_q == 7'({nbits, 1'b0} - 7'h1));
  wire s_done = ~master & sample_ev & (bitn_q == nbits - 6'h1);
  wire char_done = m_done | s_done;

  // select pin carries the sync when framed: input if the direction bit is set, else output
  wire fs_in_act = (pins.lvl[1] == fs_pol);
  wire fs_out_en = framed & ~fs_dir;
  wire slave_sel = ctrl_q[`B_SSEN] ? ~pins.lvl[1] : 1'b1;
  // input direction waits for the pulse
  wire m_go = master & tx_full_q & (~(framed & fs_dir) | fs_in_act);
  wire s_go = ~master & (framed ? (fs_dir ? fs_in_act : tx_full_q) : slave_sel);
  wire go   = on & (st_q == ST_IDLE) & (m_go | s_go);
  wire go_pre = master & fs_out_en & ~edge_sel & (char_cnt_q == 6'h0);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: if (go) st_q <= go_pre ? ST_PRE : ST_XFER;
        ST_PRE:  if (~on) st_q <= ST_IDLE;
                 else if (tick & hcnt_q[0]) st_q <= ST_XFER;
        ST_XFER: if (~on | char_done) st_q <= ST_IDLE;
                 else if (~master & ~framed & ~slave_sel) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Bit clock divider and half-period counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hp_q      <= 13'h0;
      hcnt_q    <= 7'h0;
      sck_lvl_q <= 1'b0;
    end else if (ce) begin
      if (st_q == ST_IDLE) begin
        hp_q      <= 13'h0;
        hcnt_q    <= 7'h0;
        sck_lvl_q <= ckp_eff;
      end else begin
        hp_q <= tick ? 13'h0 : hp_q + 13'h1;
        if (tick) begin
          hcnt_q <= (st_q == ST_PRE & hcnt_q[0]) ? 7'h0 : hcnt_q + 7'h1;
          if (m_run) sck_lvl_q <= ~sck_lvl_q;
        end
      end
    end
  end

  // Shift path
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_sh_q <= 32'h0;
      rx_sh_q <= 32'h0;
      bitn_q  <= 6'h0;
    end else if (ce) begin
      if (go) begin
        tx_sh_q <= tx_q << (6'd32 - nbits);
        rx_sh_q <= 32'h0;
        bitn_q  <= 6'h0;
      end else begin
        rx_sh_q <= rx_next;
        if (sample_ev) bitn_q <= bitn_q + 6'h1;
        if (shift_ev) tx_sh_q <= tx_sh_q << 1;
      end
    end
  end

  // characters counted toward the next pulse
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      char_cnt_q <= 6'h0;
    end else if (ce) begin
      if (~on | ~framed) char_cnt_q <= 6'h0;
      else if (char_done) char_cnt_q <= (char_cnt_q + 6'h1 >= frame_len) ? 6'h0 : char_cnt_q + 6'h1;
    end
  end

  wire data_wr = wr_take & on_data & (op == OP_WRITE);
  wire data_rd = rd_take & on_data & (op == OP_WRITE);
  wire rov_ev  = char_done & rbf_q & ~data_rd;
  wire stat_wr = wr_take & on_stat;
  wire [31:0] stat_upd = alias_apply({31'h0, rov_q} << `S_ROV, avs_writedata, op);

  // Buffers and flags; a set beats a clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_q      <= 32'h0;
      tx_full_q <= 1'b0;
      rx_q      <= 32'h0;
      rbf_q     <= 1'b0;
      rov_q     <= 1'b0;
    end else if (ce) begin
      if (data_wr) tx_q <= merge(tx_q, be);
      tx_full_q <= data_wr | (tx_full_q & ~go);
      if (char_done) rx_q <= rx_next & nmask;
      rbf_q <= char_done | (rbf_q & ~data_rd);
      rov_q <= rov_ev | (stat_wr ? stat_upd[`S_ROV] : rov_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_stat_q <= 32'h0;
    end else if (ce) begin
      irq_stat_q <= ({30'h0, rov_ev, char_done})
                  | (irq_stat_q & ~((wr_take & on_ist & (op == OP_WRITE)) ? avs_writedata & be : 32'h0));
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // width: whole character or one bit
  wire fs_act = fs_out_en & (char_cnt_q == 6'h0)
              & ((st_q == ST_PRE) | ((st_q == ST_XFER) & (fs_wide | (edge_sel & hcnt_q < 7'h2))));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ss_out_q <= 1'b1;
      ss_oe_q  <= 1'b0;
    end else if (ce) begin
      if (framed) begin
        ss_oe_q  <= on & ~fs_dir;
        ss_out_q <= fs_act ? fs_pol : ~fs_pol;
      end else begin
        ss_oe_q  <= on & master & ctrl_q[`B_AUTO_SEL];
        ss_out_q <= busy ? fs_pol : ~fs_pol;
      end
    end
  end

  assign ss_out  = ss_out_q;
  assign ss_oe   = ss_oe_q;
  assign sck_out = sck_lvl_q;
  assign sck_oe  = on & master;
  assign sdo     = tx_sh_q[31];
  assign sdo_oe  = on & ~ctrl_q[`B_SDO_OFF] & (master | busy);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_lock;
    wr_take & on_reg & on |=> $stable(ctrl_q & `CTRL_LOCK);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bit changed while on");

  property p_unimpl;
    (ctrl_q & ~`CTRL_MASK) == 32'h0 && (ctrl2_q & ~`CTRL2_MASK) == 32'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_set_alias;
    wr_take & on_reg & (op == OP_SET) & ~on & (&avs_byteenable)
      |=> (ctrl_q & $past(avs_writedata) & `CTRL_MASK) == ($past(avs_writedata) & `CTRL_MASK);
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias lost bits");

  property p_audio;
    audio_protocol_enable |-> ckp_eff && (st_q != ST_IDLE || sck_lvl_q || !ce || $past(!audio_protocol_enable));
  endproperty
  a_audio: assert property (p_audio) else $error("audio idle level not high");

  property p_edge_ign;
    framed |-> (sample_ev == trail) && (shift_ev == (lead && bitn_q != 6'h0));
  endproperty
  a_edge_ign: assert property (p_edge_ign) else $error("clock edge bit used when framed");

  property p_fs_in;
    ce & framed & fs_dir |=> !ss_oe;
  endproperty
  a_fs_in: assert property (p_fs_in) else $error("sync input driven");

  property p_pol;
    ce & framed & ~fs_dir & ~fs_act & on |=> ss_oe && ss_out == !$past(fs_pol);
  endproperty
  a_pol: assert property (p_pol) else $error("sync idle level wrong");

  property p_auto;
    ce & ~framed & master & ctrl_q[`B_AUTO_SEL] & on & busy |=> ss_oe && ss_out == $past(fs_pol);
  endproperty
  a_auto: assert property (p_auto) else $error("auto select not asserted");

  property p_plain;
    ce & ~framed & ~(master & ctrl_q[`B_AUTO_SEL]) |=> !ss_oe;
  endproperty
  a_plain: assert property (p_plain) else $error("select driven when unframed");

  property p_off;
    ce & ~on & busy |=> st_q == ST_IDLE;
  endproperty
  a_off: assert property (p_off) else $error("engine runs while off");

  property p_count;
    ce & char_done & framed & on & (char_cnt_q == frame_len - 6'h1) |=> char_cnt_q == 6'h0;
  endproperty
  a_count: assert property (p_count) else $error("pulse off frame boundary");

  property p_pre;
    ce & go & go_pre |=> st_q == ST_PRE && fs_act;
  endproperty
  a_pre: assert property (p_pre) else $error("lead-in pulse missing");

  property p_narrow;
    fs_act & ~fs_wide & (st_q == ST_XFER) |-> hcnt_q < 7'h2;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow pulse too long");

  property p_framed;
    ce & framed & ~fs_dir & on |=> ss_oe;
  endproperty
  a_framed: assert property (p_framed) else $error("sync output not driven");
endmodule : spi_frame_sync_control

/* spi_fs_params.svh */
/*
  Offsets, bit positions, masks and reset values of the framed serial port.
  Assumes byte addressing on the register bus, one word per register.
*/
`ifndef SPI_FS_PARAMS_SVH
`define SPI_FS_PARAMS_SVH

`define OFS_CTRL      16'h8100
`define OFS_STAT      16'h8110
`define OFS_DATA      16'h8120
`define OFS_BAUD      16'h8130
`define OFS_CTRL2     16'h8140
`define OFS_IRQ_STAT  16'h8150
`define OFS_IRQ_MASK  16'h8160

`define B_FRAMED      31
`define B_FS_DIR      30
`define B_FS_POL      29
`define B_AUTO_SEL    28
`define B_FS_WIDE     27
`define B_FCNT_LO     24
`define B_EDGE_SEL    17
`define B_ON          15
`define B_SDO_OFF     12
`define B_MODE32      11
`define B_MODE16      10
`define B_CKE         8
`define B_SSEN        7
`define B_CKP         6
`define B_MASTER      5
`define B_AUDIO       7

`define S_RBF         0
`define S_TBE         3
`define S_ROV         6
`define S_BUSY        11

`define CTRL_MASK     32'hFF83BFFF
`define CTRL_LOCK     32'h00810000
`define CTRL2_MASK    32'h00009F8B
`define BAUD_MASK     32'h00001FFF
`define IRQ_BITS      32'h00000003
`define CTRL_RESET    32'h00000000
`define STAT_RESET    32'h00000008

`endif

/* spi_fs_pkg.sv */
/*
  Types of the framed serial port.
  Assumes nothing of its surroundings.
*/
package spi_fs_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_XFER = 2'b10
  } xfer_state_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_CLR   = 2'b01,
    OP_SET   = 2'b10,
    OP_INV   = 2'b11
  } alias_op_t;

endpackage : spi_fs_pkg

/* edge_if.sv */
/*
  Pin levels in, synchronised levels and edges out.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
interface edge_if #(parameter int W = 3);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (input raw, output lvl, rise, fall);
  modport dst (output raw, input lvl, rise, fall);
endinterface : edge_if

/* pin_edge_sync.sv */
/*
  Two-flop synchroniser with edge detection for asynchronous pins.
  Assumes the pins are quiet longer than two sys_clk periods.
*/
`timescale 1ns/1ps
module pin_edge_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  edge_if.src      e
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else if (ce) begin
      s1_q <= e.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign e.lvl  = s2_q;
  assign e.rise = s2_q & ~s3_q;
  assign e.fall = ~s2_q & s3_q;
endmodule : pin_edge_sync

/* serial_peer.sv */
/*
  Serial peer on the far side of the port: counts bit clocks and frame pulses,
  loops the serial output back to the serial input.
  Drives a sync pulse on request and, for a slave port, a burst of
  16 bit-clock half periods of 80 ns; the clock stands still otherwise.
  Assumes all pins are sampled on sys_clk.
*/
`timescale 1ns/1ps
module serial_peer (
  input  wire logic sys_clk,
  input  wire logic clr,
  input  wire logic pol,
  input  wire logic sck_out,
  input  wire logic ss_out,
  input  wire logic ss_oe,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  input  wire logic fs_drv,
  input  wire logic burst,
  output logic      sck_in,
  output logic      ss_in,
  output logic      sdi,
  output int        rises,
  output int        pulses,
  output int        plen,
  output int        ptog
);
  logic sck_q = 1'b0;
  logic act_q = 1'b0;
  logic sdo_q = 1'b0;
  logic act;
  int   cl    = 0;
  int   ct    = 0;
  logic sck_drv_q = 1'b0;
  int   hp    = 0;
  int   tg    = 0;

  assign act    = ss_oe && (ss_out == pol);
  // Select line has a pull-up; pulled to the active level for a sync pulse
  assign sck_in = sck_drv_q;
  assign ss_in  = fs_drv ? pol : 1'b1;

  // Bit clock burst: 160 ns period, idle low between bursts
  always @(posedge sys_clk) begin
    if (burst) begin
      tg <= 16;
      hp <= 0;
    end else if (tg > 0) begin
      if (hp == 9) begin
        hp        <= 0;
        tg        <= tg - 1;
        sck_drv_q <= ~sck_drv_q;
      end else begin
        hp <= hp + 1;
      end
    end
  end
  // Released data line shows the inverse of its last value
  assign sdi    = sdo_oe ? sdo : ~sdo_q;

  always @(posedge sys_clk) begin
    sck_q <= sck_out;
    act_q <= act;
    if (sdo_oe) sdo_q <= sdo;
    if (clr) begin
      rises <= 0; pulses <= 0; plen <= 0; ptog <= 0; cl <= 0; ct <= 0;
    end else begin
      if (sck_out && !sck_q) rises <= rises + 1;
      if (act && !act_q) begin
        pulses <= pulses + 1;
        cl     <= 1;
        ct     <= int'(sck_out != sck_q);
      end else if (act) begin
        cl <= cl + 1;
        ct <= ct + int'(sck_out != sck_q);
      end
      if (!act && act_q) begin
        plen <= cl;
        ptog <= ct;
      end
    end
  end
endmodule : serial_peer

/* spi_frame_sync_control_tb.sv */
/*
  Register-level test of the framed serial port over Avalon-MM.
  Assumes the peer model loops data back and bit half period is BAUD+1 cycles.
*/
`timescale 1ns/1ps
`include "spi_fs_params.svh"
module spi_frame_sync_control_tb;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd_s, v;
  logic        avs_waitrequest, wait_s, sck_out, sck_oe, ss_out, ss_oe;
  logic        sdo, sdo_oe, irq, sck_in, ss_in, sdi;
  logic        fpol = 1'b0;
  logic        pclr = 1'b0;
  logic        ce = 1'b1;
  logic        fs_drv = 1'b0;
  logic        burst = 1'b0;
  int          rises, pulses, plen, ptog, i, k, j;
  int          miscompares = 0;
  int          n_checks = 0;
  int          nch [7] = '{2, 4, 4, 8, 16, 32, 2};
  int          npul [7] = '{2, 2, 1, 1, 1, 1, 2};

  spi_frame_sync_control i_spi_frame_sync_control (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .ss_in(ss_in), .ss_out(ss_out), .ss_oe(ss_oe), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .irq(irq));
  serial_peer i_serial_peer (
    .sys_clk(sys_clk), .clr(pclr), .pol(fpol), .sck_out(sck_out), .ss_out(ss_out),
    .ss_oe(ss_oe), .sdo(sdo), .sdo_oe(sdo_oe), .fs_drv(fs_drv), .burst(burst),
    .sck_in(sck_in), .ss_in(ss_in),
    .sdi(sdi), .rises(rises), .pulses(pulses), .plen(plen), .ptog(ptog));

  always #4 sys_clk = ~sys_clk;
  // Values that the next rising edge will see
  always @(negedge sys_clk) begin
    wait_s = avs_waitrequest;
    rd_s   = avs_readdata;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge sys_clk);
    end while (wait_s !== 1'b0);
    q = rd_s;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task rchk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk($sformatf("reg %h", a), q, e);
  endtask : rchk

  task wait_done;
    logic [31:0] q;
    q = 32'h00000000;
    for (int n = 0; n < 100 && q[0] !== 1'b1; n++) bus(1'b0, `OFS_IRQ_STAT, 32'h0, q);
    chk("char done", q[0], 1'b1);
    wr(`OFS_IRQ_STAT, 32'h00000001);
  endtask : wait_done

  task xfer(input logic [31:0] d);
    wr(`OFS_DATA, d);
    wait_done();
  endtask : xfer

  task clr_peer;
    pclr <= 1'b1;
    @(posedge sys_clk);
    pclr <= 1'b0;
  endtask : clr_peer

  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rchk(`OFS_CTRL, `CTRL_RESET);
    rchk(`OFS_STAT, `STAT_RESET);
    rchk(`OFS_DATA, 32'h00000000);
    rchk(`OFS_BAUD, 32'h00000000);
    rchk(`OFS_CTRL2, 32'h00000000);
    rchk(`OFS_IRQ_MASK, 32'h00000000);
    wr(16'h8170, 32'hFFFFFFFF);
    rchk(16'h8170, 32'h00000000);
    wr(`OFS_CTRL, 32'hFFFFFFFF);
    rchk(`OFS_CTRL, `CTRL_MASK);
    wr(`OFS_CTRL + 16'h4, 32'h00008000);
    rchk(`OFS_CTRL, 32'hFF833FFF);
    wr(`OFS_CTRL + 16'h4, 32'hFFFFFFFF);
    rchk(`OFS_CTRL, 32'h00000000);
    wr(`OFS_CTRL + 16'h8, 32'h008100F0);
    rchk(`OFS_CTRL, 32'h008100F0);
    wr(`OFS_CTRL + 16'hC, 32'h000080FF);
    rchk(`OFS_CTRL, 32'h0081800F);
    wr(`OFS_CTRL + 16'h4, 32'h00810000);
    rchk(`OFS_CTRL, 32'h0081800F);
    wr(`OFS_CTRL, 32'h00000000);
    rchk(`OFS_CTRL, 32'h00810000);
    wr(`OFS_CTRL, 32'h00000000);
    rchk(`OFS_CTRL, 32'h00000000);
    wr(`OFS_CTRL2, 32'hFFFFFFFF);
    rchk(`OFS_CTRL2, `CTRL2_MASK);
    wr(`OFS_CTRL2 + 16'h4, 32'hFFFFFFFF);
    rchk(`OFS_CTRL2, 32'h00000000);
    avs_byteenable <= 4'h1;
    wr(`OFS_BAUD, 32'hFFFFFFFF);
    avs_byteenable <= 4'hF;
    rchk(`OFS_BAUD, 32'h000000FF);
    // Half period of 10 cycles: 160 ns bit clock, well above the pin sync delay
    wr(`OFS_BAUD, 32'h00000009);
    // Audio mode idles the bit clock high
    wr(`OFS_CTRL, 32'h00008020);
    repeat (4) @(posedge sys_clk);
    chk("sck idle", sck_out, 1'b0);
    chk("sck oe", sck_oe, 1'b1);
    chk("sdo oe", sdo_oe, 1'b1);
    wr(`OFS_CTRL2, 32'h00000080);
    repeat (4) @(posedge sys_clk);
    chk("sck idle audio", sck_out, 1'b1);
    wr(`OFS_CTRL2, 32'h00000000);
    // Loaded while off: no clocks until switched on
    wr(`OFS_CTRL, 32'h00000020);
    clr_peer();
    wr(`OFS_DATA, 32'h0000005A);
    repeat (40) @(posedge sys_clk);
    chk("clocks off", rises, 0);
    wr(`OFS_CTRL, 32'h00008020);
    wait_done();
    chk("clocks on", rises, 8);
    rchk(`OFS_DATA, 32'h0000005A);
    // Unframed: frame fields have no effect
    wr(`OFS_CTRL, 32'h2B008020);
    repeat (4) @(posedge sys_clk);
    chk("plain select oe", ss_oe, 1'b0);
    // Auto select, active high
    fpol <= 1'b1;
    wr(`OFS_CTRL, 32'h30008020);
    clr_peer();
    xfer(32'h000000C3);
    chk("select pulses", pulses, 1);
    chk("clocks in select", ptog, 16);
    chk("select idle", ss_out, 1'b0);
    rchk(`OFS_DATA, 32'h000000C3);
    wr(`OFS_IRQ_MASK, 32'h00000001);
    wr(`OFS_DATA, 32'h0000003C);
    // Clock enable low freezes the bit clock before the first edge of a character
    ce <= 1'b0;
    repeat (2) @(posedge sys_clk);
    k = rises;
    repeat (30) @(posedge sys_clk);
    chk("frozen clock", rises, k);
    ce <= 1'b1;
    j = 0;
    while (irq !== 1'b1 && j < 400) begin
      @(posedge sys_clk);
      j++;
    end
    chk("irq", irq, 1'b1);
    wr(`OFS_IRQ_MASK, 32'h00000000);
    chk("irq masked", irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h00000001);
    chk("irq unmasked", irq, 1'b1);
    wr(`OFS_IRQ_STAT, 32'h00000001);
    chk("irq cleared", irq, 1'b0);
    rchk(`OFS_IRQ_STAT, 32'h00000000);
    // Pulses per character count, reserved code 6 included
    for (k = 0; k < 7; k++) begin
      wr(`OFS_CTRL, 32'h00000000);
      wr(`OFS_CTRL, 32'hA0008020 | (k << 24));
      @(posedge sys_clk);
      chk("sync out oe", ss_oe, 1'b1);
      clr_peer();
      for (i = 0; i < nch[k]; i++) xfer(i);
      chk($sformatf("pulses code %0d", k), pulses, npul[k]);
    end
    // Active-low, one bit wide, before the first clock; clock edge bit set
    fpol <= 1'b0;
    wr(`OFS_CTRL, 32'h00000000);
    wr(`OFS_CTRL, 32'h80008120);
    clr_peer();
    xfer(32'h00000096);
    chk("bit pulse len", plen, 20);
    chk("lead-in clocks", ptog, 0);
    chk("clocks", rises, 8);
    rchk(`OFS_DATA, 32'h00000096);
    // One character wide, then one bit wide, each coincident with the first clock
    wr(`OFS_CTRL, 32'h00000000);
    wr(`OFS_CTRL, 32'h88028020);
    xfer(32'h00000069);
    chk("char pulse len", plen, 160);
    wr(`OFS_CTRL, 32'h00000000);
    wr(`OFS_CTRL, 32'h80028020);
    xfer(32'h00000011);
    chk("clock in pulse", ptog != 0, 1);
    wr(`OFS_CTRL, 32'hC0008020);
    repeat (4) @(posedge sys_clk);
    chk("sync in oe", ss_oe, 1'b0);
    // Sync input: loaded character waits for the peer's pulse
    clr_peer();
    wr(`OFS_DATA, 32'h000000A5);
    repeat (40) @(posedge sys_clk);
    chk("clocks before sync", rises, 0);
    fs_drv <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fs_drv <= 1'b0;
    wait_done();
    chk("clocks after sync", rises, 8);
    rchk(`OFS_DATA, 32'h000000A5);
    // Slave, select unused: the peer clocks one character through
    wr(`OFS_CTRL, 32'h00000000);
    wr(`OFS_DATA, 32'h0000003C);
    wr(`OFS_CTRL, 32'h00008000);
    burst <= 1'b1;
    @(posedge sys_clk);
    burst <= 1'b0;
    wait_done();
    chk("slave sck oe", sck_oe, 1'b0);
    rchk(`OFS_DATA, 32'h0000003C);
    print_verdict();
  end
endmodule : spi_frame_sync_control_tb
